// [shared/pssl_pkg.sv]
package pssl_pkg;

    // Clock and serial timing
    localparam int          CLK_HZ          = 200_000_000;
    localparam int          TOL_PPM         = 100;
    localparam int          NUM_RATES       = 9;
    localparam int          DIV_W           = 17;
    localparam int          SYNC_STAGES     = 3;
    localparam logic [3:0]  RATE_RST        = 4'h2;
    localparam logic [3:0]  DATA_BITS       = 4'h8;

    // Baud rate index decode, cycles per bit rounded to nearest
    function automatic logic [DIV_W-1:0] pssl_bit_cycles(input logic [3:0] rate);
        int baud;
        case (rate)
            4'h0:    baud = 2400;
            4'h1:    baud = 4800;
            4'h2:    baud = 9600;
            4'h3:    baud = 19200;
            4'h4:    baud = 38400;
            4'h5:    baud = 57600;
            4'h6:    baud = 76800;
            4'h7:    baud = 115200;
            4'h8:    baud = 153600;
            default: baud = 9600;
        endcase
        pssl_bit_cycles = DIV_W'((CLK_HZ + baud / 2) / baud);
    endfunction : pssl_bit_cycles

    // Sideband pin bundle toward the target
    typedef struct packed {
        logic reset_req_o;
        logic reset_req_oe;
        logic sense_i_o;
        logic sense_i_oe;
    } pssl_side_out_t;

    // Received byte with framing status
    typedef struct packed {
        logic       valid;
        logic       frame_err;
        logic [7:0] data;
    } pssl_rx_t;

endpackage : pssl_pkg

// [rtl/pssl_sync.sv]
`timescale 1ns/1ps
// Three-stage synchroniser with agreement filter
module pssl_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic clk_en,
    // Asynchronous input and filtered level
    input  wire logic din,
    output logic      dout
);
    logic [2:0] sync_reg;
    logic       dout_reg;
    wire        agree = (sync_reg[1] == sync_reg[2]);

    // Shift chain; stage 0 feeds only stage 1
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync_reg <= 3'h0;
            dout_reg <= 1'b0;
        end else if (clk_en) begin
            sync_reg <= {sync_reg[1:0], din};
            if (agree) begin
                dout_reg <= sync_reg[2];
            end
        end
    end

    assign dout = dout_reg;
endmodule : pssl_sync

// [rtl/pssl_initiator.sv]
`timescale 1ns/1ps
// Initiator port: serial link plus sideband lines
module pssl_initiator
    import pssl_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    // User control
    input  wire logic [3:0]           rate_sel,
    input  wire logic                 present,
    input  wire logic                 reset_req,
    input  wire logic                 active_negate,
    // User transmit stream
    input  wire logic                 tx_valid,
    input  wire logic [7:0]           tx_data,
    output logic                      tx_ready,
    // User receive stream and status
    output pssl_pkg::pssl_rx_t        rx_out,
    output logic                      attention,
    output logic                      attention_rise,
    output logic                      target_present,
    // Link pins
    output logic                      txd,
    input  wire logic                 rxd,
    input  wire logic                 attention_in,
    input  wire logic                 sense_t_in,
    output pssl_pkg::pssl_side_out_t  side_out
);
    import pssl_pkg::*;

    typedef enum logic [1:0] {PSSL_IDLE, PSSL_START, PSSL_DATA, PSSL_STOP} pssl_state_t;

    // Synchronised inputs
    logic rxd_s, attn_s, sense_s;
    logic [2:0] sync_in;
    logic [2:0] sync_out;
    assign sync_in = {~rxd, attention_in, sense_t_in}; // Serial line inverted: cleared chain reads idle

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            pssl_sync u_sync (
                .clock  (clock),
                .rst_n  (rst_n),
                .clk_en (clk_en),
                .din    (sync_in[g]),
                .dout   (sync_out[g])
            );
        end
    endgenerate
    assign rxd_s   = ~sync_out[2]; // No false start bit after reset
    assign attn_s  = sync_out[1];
    assign sense_s = sync_out[0];

    // Rate latched only while both ends idle
    logic [3:0]       rate_reg;
    logic [DIV_W-1:0] bit_cyc;
    wire              rate_ok = (rate_sel < 4'(NUM_RATES));
    assign bit_cyc = pssl_bit_cycles(rate_reg);

    // Transmitter
    pssl_state_t      tx_st_reg;
    logic [DIV_W-1:0] tx_cnt_reg;
    logic [3:0]       tx_bit_reg;
    logic [7:0]       tx_sh_reg;
    logic             txd_reg;
    logic             tx_ready_reg;
    wire              tx_tick = (tx_cnt_reg == bit_cyc - DIV_W'(1));
    wire              tx_take = tx_ready_reg && tx_valid;

    // Receiver
    pssl_state_t      rx_st_reg;
    logic [DIV_W-1:0] rx_cnt_reg;
    logic [3:0]       rx_bit_reg;
    logic [7:0]       rx_sh_reg;
    pssl_rx_t         rx_reg;
    wire              rx_tick = (rx_cnt_reg == bit_cyc - DIV_W'(1));
    wire              rx_mid  = (rx_cnt_reg == (bit_cyc >> 1));

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rate_reg <= RATE_RST;
        end else if (clk_en && tx_st_reg == PSSL_IDLE && rx_st_reg == PSSL_IDLE && rate_ok) begin
            rate_reg <= rate_sel;
        end
    end

    // Serialiser: start bit, eight data bits LSB first, stop bit
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_st_reg    <= PSSL_IDLE;
            tx_cnt_reg   <= '0;
            tx_bit_reg   <= 4'h0;
            tx_sh_reg    <= 8'h00;
            txd_reg      <= 1'b1;
            tx_ready_reg <= 1'b0;
        end else if (clk_en) begin
            case (tx_st_reg)
                PSSL_IDLE: begin
                    txd_reg      <= 1'b1;
                    tx_cnt_reg   <= '0;
                    tx_ready_reg <= !tx_take;
                    if (tx_take) begin
                        tx_sh_reg <= tx_data;
                        txd_reg   <= 1'b0;
                        tx_st_reg <= PSSL_START;
                    end
                end
                PSSL_START, PSSL_DATA: begin
                    tx_cnt_reg <= tx_tick ? '0 : tx_cnt_reg + DIV_W'(1);
                    if (tx_tick) begin
                        txd_reg    <= tx_sh_reg[0];
                        tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
                        tx_bit_reg <= (tx_st_reg == PSSL_START) ? 4'h0 : tx_bit_reg + 4'h1;
                        if (tx_st_reg == PSSL_START) begin
                            tx_st_reg <= PSSL_DATA;
                        end else if (tx_bit_reg == DATA_BITS - 4'h1) begin
                            txd_reg   <= 1'b1;
                            tx_st_reg <= PSSL_STOP;
                        end
                    end
                end
                PSSL_STOP: begin
                    tx_cnt_reg <= tx_tick ? '0 : tx_cnt_reg + DIV_W'(1);
                    if (tx_tick) begin
                        tx_st_reg    <= PSSL_IDLE;
                        tx_ready_reg <= 1'b1;
                    end
                end
                default: tx_st_reg <= PSSL_IDLE;
            endcase
        end
    end

    // Deserialiser sampling mid-bit
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_st_reg  <= PSSL_IDLE;
            rx_cnt_reg <= '0;
            rx_bit_reg <= 4'h0;
            rx_sh_reg  <= 8'h00;
            rx_reg     <= '0;
        end else if (clk_en) begin
            rx_reg.valid <= 1'b0;
            case (rx_st_reg)
                PSSL_IDLE: begin
                    rx_cnt_reg <= '0;
                    rx_bit_reg <= 4'h0;
                    if (!rxd_s) begin
                        rx_st_reg <= PSSL_START;
                    end
                end
                PSSL_START: begin
                    rx_cnt_reg <= rx_cnt_reg + DIV_W'(1);
                    if (rx_mid) begin
                        rx_cnt_reg <= '0;
                        rx_st_reg  <= rxd_s ? PSSL_IDLE : PSSL_DATA;
                    end
                end
                PSSL_DATA: begin
                    rx_cnt_reg <= rx_tick ? '0 : rx_cnt_reg + DIV_W'(1);
                    if (rx_tick) begin
                        rx_sh_reg  <= {rxd_s, rx_sh_reg[7:1]};
                        rx_bit_reg <= rx_bit_reg + 4'h1;
                        if (rx_bit_reg == DATA_BITS - 4'h1) begin
                            rx_st_reg <= PSSL_STOP;
                        end
                    end
                end
                PSSL_STOP: begin
                    rx_cnt_reg <= rx_tick ? '0 : rx_cnt_reg + DIV_W'(1);
                    if (rx_tick) begin
                        rx_reg.valid     <= 1'b1;
                        rx_reg.frame_err <= !rxd_s;
                        rx_reg.data      <= rx_sh_reg;
                        rx_st_reg        <= PSSL_IDLE;
                    end
                end
                default: rx_st_reg <= PSSL_IDLE;
            endcase
        end
    end

    // Sideband outputs and status
    logic           attn_reg;
    logic           attn_rise_reg;
    logic           tpres_reg;
    pssl_side_out_t side_reg;
    pssl_side_out_t side_next;

    assign side_next.reset_req_o  = reset_req;
    assign side_next.reset_req_oe = reset_req || active_negate;
    assign side_next.sense_i_o    = present;
    assign side_next.sense_i_oe   = present || active_negate;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            attn_reg      <= 1'b0;
            attn_rise_reg <= 1'b0;
            tpres_reg     <= 1'b0;
            side_reg      <= '0;
        end else if (clk_en) begin
            attn_reg      <= attn_s;
            attn_rise_reg <= attn_s && !attn_reg;
            tpres_reg     <= sense_s;
            side_reg      <= side_next;
        end
    end

    // Released lines read as zero via the synchroniser
    assign tx_ready       = tx_ready_reg;
    assign txd            = txd_reg;
    assign rx_out         = rx_reg;
    assign attention      = attn_reg;
    assign attention_rise = attn_rise_reg;
    assign target_present = tpres_reg;
    assign side_out       = side_reg;

    // Checks
    drive_true_a: assert property (@(posedge clock) disable iff (!rst_n)
        side_out.reset_req_o |-> side_out.reset_req_oe)
        else $error("reset request asserted but not driven");
    sense_drive_a: assert property (@(posedge clock) disable iff (!rst_n)
        side_out.sense_i_o |-> side_out.sense_i_oe)
        else $error("presence asserted but not driven");
    pres_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && present ##1 clk_en |-> side_out.sense_i_o)
        else $error("presence not held");
    reset_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && reset_req ##1 clk_en |-> side_out.reset_req_o)
        else $error("reset request not forwarded");
    attn_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(attention_rise) |-> attention && !$past(attention))
        else $error("attention edge without rise");
    tx_start_a: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && tx_take |=> txd == 1'b0)
        else $error("start bit missing");
    tx_ready_a: assert property (@(posedge clock) disable iff (!rst_n)
        tx_st_reg != PSSL_IDLE |-> !tx_ready)
        else $error("ready while sending");
    rate_range_a: assert property (@(posedge clock) disable iff (!rst_n)
        rate_reg < 4'(NUM_RATES))
        else $error("rate index out of range");
    rx_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(rx_out.valid) |-> $past(rx_st_reg) == PSSL_STOP)
        else $error("byte without stop bit");

endmodule : pssl_initiator

// [dv/pssl_target_model.sv]
`timescale 1ns/1ps
// Behavioural target port facing the initiator
module pssl_target_model
    import pssl_pkg::*;
(
    // Clock
    input  wire logic                     clock,
    // Link pins
    input  wire logic                     txd,
    output logic                          rxd,
    output logic                          attention_in,
    output logic                          sense_t_in,
    input  wire pssl_pkg::pssl_side_out_t side_out,
    // Resolved sideband levels
    output logic                          reset_seen,
    output logic                          initiator_seen
);
    import pssl_pkg::*;

    // Released lines read false through the bias
    assign reset_seen     = side_out.reset_req_oe & side_out.reset_req_o;
    assign initiator_seen = side_out.sense_i_oe & side_out.sense_i_o;

    // Idle line high, sideband negated
    initial begin
        rxd          = 1'b1;
        attention_in = 1'b0;
        sense_t_in   = 1'b0;
    end

    // Held levels for attention and presence
    task automatic set_lines(input logic att, input logic pres);
        attention_in = att;
        sense_t_in   = pres;
    endtask : set_lines

    // Frame toward the initiator, LSB first
    task automatic send_byte(input logic [7:0] d, input logic stop, input int n);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int b = 0; b < 10; b++) begin
            rxd = f[b];
            repeat (n) @(negedge clock);
        end
        rxd = 1'b1;
    endtask : send_byte

    // Mid-bit sampling of one frame from the initiator
    task automatic recv_byte(input int n, output logic [7:0] d, output logic stop,
                             output logic ok);
        int c;
        c = 0;
        while (txd !== 1'b0 && c < 40000) begin
            @(posedge clock);
            c++;
        end
        repeat (n / 2) @(posedge clock);
        ok = (c < 40000) && (txd === 1'b0);
        for (int b = 0; b < 8; b++) begin
            repeat (n) @(posedge clock);
            d[b] = txd;
        end
        repeat (n) @(posedge clock);
        stop = txd;
    endtask : recv_byte

endmodule : pssl_target_model

// [dv/tb.sv]
`timescale 1ns/1ps
// Self-checking bench for the initiator port
module tb;
    import pssl_pkg::*;

    // Bit lengths at the two fastest rates
    localparam int N8 = (200_000_000 + 76_800) / 153_600;
    localparam int N7 = (200_000_000 + 57_600) / 115_200;

    // Design and model signals
    logic           clock = 1'b0;
    logic           rst_n = 1'b0;
    logic           clk_en = 1'b1;
    logic [3:0]     rate_sel = 4'h8;
    logic           present = 1'b0;
    logic           reset_req = 1'b0;
    logic           active_negate = 1'b0;
    logic           tx_valid = 1'b0;
    logic [7:0]     tx_data = 8'h00;
    logic           tx_ready, attention, attention_rise, target_present;
    logic           txd, rxd, attention_in, sense_t_in, reset_seen, initiator_seen;
    pssl_rx_t       rx_out;
    pssl_side_out_t side_out;
    int             bad_count = 0;
    int             checks_done = 0;

    pssl_initiator i_pssl_initiator (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
        .rate_sel(rate_sel), .present(present), .reset_req(reset_req),
        .active_negate(active_negate), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_out(rx_out), .attention(attention),
        .attention_rise(attention_rise), .target_present(target_present), .txd(txd),
        .rxd(rxd), .attention_in(attention_in), .sense_t_in(sense_t_in), .side_out(side_out));

    pssl_target_model target (.clock(clock), .txd(txd), .rxd(rxd),
        .attention_in(attention_in), .sense_t_in(sense_t_in), .side_out(side_out),
        .reset_seen(reset_seen), .initiator_seen(initiator_seen));

    // Clock generation
    initial begin
        forever #2.5 clock = ~clock;
    end

    // Verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // Compare tasks
    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : chk_bit

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h", $time, what, got);
        end
    endtask : chk_byte

    // Bounded wait: 0 tx_ready, 1 rx valid, 2 attention rise
    task automatic wait_until(input int sel, input int lim);
        int c;
        c = 0;
        while (!((sel == 0 && tx_ready === 1'b1) || (sel == 1 && rx_out.valid === 1'b1)
                 || (sel == 2 && attention_rise === 1'b1))) begin
            @(posedge clock);
            #1;
            c++;
            if (c > lim) begin
                bad_count++;
                $display("CHECK FAILED at %0t: wait %0d timed out", $time, sel);
                final_report();
            end
        end
    endtask : wait_until

    // Sideband drive, release, sense and attention
    task automatic test_side();
        present = 1'b1;
        repeat (2) @(negedge clock);
        chk_bit(side_out.sense_i_oe, 1'b1, "presence not driven");
        repeat (40) @(negedge clock);
        chk_bit(initiator_seen, 1'b1, "presence not held");
        present = 1'b0;
        repeat (2) @(negedge clock);
        chk_bit(side_out.sense_i_oe, 1'b0, "negated presence driven");
        chk_bit(initiator_seen, 1'b0, "released line not false");
        active_negate = 1'b1;
        reset_req = 1'b1;
        repeat (2) @(negedge clock);
        chk_bit(reset_seen, 1'b1, "reset request missing");
        reset_req = 1'b0;
        repeat (2) @(negedge clock);
        chk_bit(side_out.reset_req_oe, 1'b1, "negate not driven");
        chk_bit(side_out.reset_req_o, 1'b0, "negate level wrong");
        target.set_lines(1'b1, 1'b1);
        @(posedge clock);
        #1;
        chk_bit(attention, 1'b0, "attention not synchronised");
        wait_until(2, 8);
        @(posedge clock);
        #1;
        chk_bit(attention_rise, 1'b0, "rise pulse too long");
        chk_bit(attention, 1'b1, "attention level lost");
        repeat (4) @(negedge clock);
        chk_bit(target_present, 1'b1, "target presence missed");
        target.set_lines(1'b0, 1'b0);
        repeat (8) @(negedge clock);
        chk_bit(attention, 1'b0, "attention stuck");
        chk_bit(target_present, 1'b0, "target absence missed");
        clk_en = 1'b0;
        present = 1'b1;
        repeat (4) @(negedge clock);
        chk_bit(side_out.sense_i_o, 1'b0, "state moved while frozen");
        clk_en = 1'b1;
        repeat (2) @(negedge clock);
        chk_bit(side_out.sense_i_o, 1'b1, "presence after freeze");
        present = 1'b0;
        $display("test sideband done");
    endtask : test_side

    // Reset in mid-run returns pins to idle
    task automatic test_mid_reset();
        present = 1'b1;
        repeat (2) @(negedge clock);
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        chk_byte(8'(side_out), 8'h00, "side pins after reset");
        chk_bit(tx_ready, 1'b0, "ready during reset");
        rst_n = 1'b1;
        repeat (2) @(negedge clock);
        chk_bit(side_out.sense_i_o, 1'b1, "presence after reset");
        wait_until(0, 4);
        present = 1'b0;
        $display("test mid reset done");
    endtask : test_mid_reset

    // One transmitted frame at a chosen rate index
    task automatic test_tx(input logic [3:0] rs, input int n, input logic [7:0] d);
        logic [7:0] got;
        logic       stop;
        logic       ok;
        rate_sel = rs;
        repeat (4) @(negedge clock);
        wait_until(0, 40000);
        @(negedge clock);
        tx_valid = 1'b1;
        tx_data  = d;
        @(negedge clock);
        tx_valid = 1'b0;
        chk_bit(tx_ready, 1'b0, "busy not shown");
        target.recv_byte(n, got, stop, ok);
        chk_bit(ok, 1'b1, "start bit missing");
        chk_byte(got, d, "tx data");
        chk_bit(stop, 1'b1, "tx stop bit");
        wait_until(0, n);
        $display("test tx %h done", d);
    endtask : test_tx

    // One received frame, stop bit chosen
    task automatic test_rx(input logic [7:0] d, input logic stop);
        fork
            target.send_byte(d, stop, N8);
            begin
                wait_until(1, 12 * N8);
                chk_byte(rx_out.data, d, "rx data");
                chk_bit(rx_out.frame_err, ~stop, "frame error flag");
                @(posedge clock);
                #1;
                chk_bit(rx_out.valid, 1'b0, "valid too long");
            end
        join
        $display("test rx %h done", d);
    endtask : test_rx

    // Main sequence
    initial begin
        repeat (3) @(negedge clock);
        chk_bit(txd, 1'b1, "txd not idle in reset");
        chk_byte(8'(side_out), 8'h00, "side pins in reset");
        chk_bit(rx_out === '0, 1'b1, "rx output in reset");
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        $display("test reset done");
        test_side();
        test_tx(4'hf, N8, 8'ha5);
        test_tx(4'h7, N7, 8'h3c);
        rate_sel = 4'h8;
        repeat (4) @(negedge clock);
        test_rx(8'h5a, 1'b1);
        test_rx(8'h81, 1'b1);
        test_rx(8'hc3, 1'b0);
        test_mid_reset();
        final_report();
    end

endmodule : tb
